// File: hw/ipm_params.svh
// Constants shared by both ends of the interface performance monitor.
// Assumes inclusion by bare name from the package and the modules.
`ifndef IPM_PARAMS_SVH
`define IPM_PARAMS_SVH

`define IPM_CNT_W        32
`define IPM_NUM_CNT      6
`define IPM_IDX_W        3
`define IPM_OUTST_MAX    32
`define IPM_PTR_W        5
`define IPM_FILL_W       6
// Counter indices on the sample port
`define IPM_IDX_WR_BYTES 3'h0
`define IPM_IDX_WR_LAT   3'h1
`define IPM_IDX_WR_TRANS 3'h2
`define IPM_IDX_RD_BYTES 3'h3
`define IPM_IDX_RD_LAT   3'h4
`define IPM_IDX_RD_TRANS 3'h5
// Sample interval timing
`define IPM_SAMPLE_MS    50
`define IPM_CLK_MHZ      100
`define IPM_SAMPLE_CYC   (`IPM_SAMPLE_MS * 1000 * `IPM_CLK_MHZ)

`endif

// File: hw/ipm_pkg.sv
// Types shared by both ends of the interface performance monitor.
// Assumes ipm_params.svh is on the include path.
`include "ipm_params.svh"

package ipm_pkg;

  typedef logic [`IPM_CNT_W-1:0] ipm_word_t;

  // Monitor state: counters, start-stamp queues per direction, sample port
  typedef struct packed {
    logic [`IPM_NUM_CNT-1:0][`IPM_CNT_W-1:0]        cnt;
    logic [`IPM_CNT_W-1:0]                          now;
    logic [1:0][`IPM_OUTST_MAX-1:0][`IPM_CNT_W-1:0] stamp;
    logic [1:0][`IPM_PTR_W-1:0]                     head;
    logic [1:0][`IPM_PTR_W-1:0]                     tail;
    logic [1:0][`IPM_FILL_W-1:0]                    fill;
    logic [1:0][`IPM_FILL_W-1:0]                    early;
    logic                                           ack;
    logic [`IPM_CNT_W-1:0]                          data;
    logic                                           fault;
  } ipm_mon_t;

  typedef enum logic [4:0] {
    IPM_WAIT  = 5'h01,
    IPM_FETCH = 5'h02,
    IPM_DIVW  = 5'h04,
    IPM_DIVR  = 5'h08,
    IPM_DONE  = 5'h10
  } ipm_host_st_t;

  // Sampler state: interval timer, previous snapshot, deltas, divider
  typedef struct packed {
    ipm_host_st_t                                   st;
    logic [`IPM_CNT_W-1:0]                          timer;
    logic [`IPM_IDX_W-1:0]                          idx;
    logic [`IPM_NUM_CNT-1:0][`IPM_CNT_W-1:0]        prev;
    logic [`IPM_NUM_CNT-1:0][`IPM_CNT_W-1:0]        delta;
    logic [`IPM_CNT_W-1:0]                          rem;
    logic [`IPM_CNT_W-1:0]                          quo;
    logic [5:0]                                     step;
    logic [`IPM_CNT_W-1:0]                          avgWr;
    logic [`IPM_CNT_W-1:0]                          avgRd;
    logic                                           done;
    logic                                           primed;
  } ipm_host_t;

endpackage

// File: hw/ipm_if.sv
// Link between the monitor and the host sampler, plus the observed AXI
// handshake signals. The bench drives the AXI side; no clocking block.
`timescale 1ns/10ps
`include "ipm_params.svh"

interface ipm_if #(
  parameter int DATA_W = 32
);
  // Observed AXI handshakes on the monitored interface
  logic                    awValid;
  logic                    awReady;
  logic                    wValid;
  logic                    wReady;
  logic                    wLast;
  logic [DATA_W/8-1:0]     wStrb;
  logic                    arValid;
  logic                    arReady;
  logic                    rValid;
  logic                    rReady;
  logic                    rLast;
  // Counter sample port
  logic                    sampleReq;
  logic [`IPM_IDX_W-1:0]   sampleIdx;
  logic                    sampleAck;
  logic [`IPM_CNT_W-1:0]   sampleData;

  modport monitor (
    input  awValid, awReady, wValid, wReady, wLast, wStrb,
    input  arValid, arReady, rValid, rReady, rLast,
    input  sampleReq, sampleIdx,
    output sampleAck, sampleData
  );

  modport sampler (
    output sampleReq, sampleIdx,
    input  sampleAck, sampleData
  );
endinterface

// File: hw/ipm_monitor.sv
// Passive profile monitor: six running counters for one AXI interface.
// Assumes the observed AXI signals are on mclk and traffic is in order.
//
// Notes on behaviour
// - Six counters per monitored interface
// - Counters count up and wrap modulo 2^32, sampling never clears
// - Transaction count bumps on last beat
// - Read latency starts at address handshake
// - Read latency ends at last read beat
// - Traffic keeps at most 32 outstanding
// - Traffic never interleaves transactions
// - Host derives throughput, latency from deltas
// - Host samples about every 50 ms
// - Counters readable while traffic runs
`timescale 1ns/10ps
`include "ipm_params.svh"

module ipm_monitor #(
  parameter int DATA_W = 32,
  parameter int DEPTH  = `IPM_OUTST_MAX
) (
  input  wire logic  mclk,
  input  wire logic  sys_rst,
  ipm_if.monitor     bus,
  output logic       trackFault
);

  localparam int BYTES = DATA_W / 8;

  // How the latency bookkeeping works
  //
  // Every accepted address leaves a time stamp in a small queue, one queue
  // per direction. The stamp is the value of a free-running cycle counter
  // in the cycle of the address handshake. When the last beat of a
  // transaction is handshaken, the oldest stamp is taken off the queue and
  // the distance from it to the present cycle is added to the latency
  // total. Because the counter and the totals both wrap modulo 2^32, the
  // distance stays right across a wrap of the cycle counter as long as no
  // single transaction lasts 2^32 cycles.
  //
  // Taking the oldest stamp is only correct while completions arrive in
  // address order and never interleave. Traffic that breaks this still
  // counts bytes and transactions exactly, but the latency total is then
  // meaningless; nothing here can detect it.
  //
  // A last beat may also arrive before its own address (write data may
  // lead the write address). Such a transaction is counted with a latency
  // of zero, and a tally of early completions makes the next address skip
  // its stamp so the queue stays paired with the data.
  //
  // Both the stamp queue and the early tally are limited to DEPTH entries.
  // Passing either limit drops the event from latency tracking and sets a
  // sticky fault flag that only reset clears; the counters themselves keep
  // running so throughput figures remain usable.
  //
  // Counters are never cleared by a sample. The host works with the
  // difference between two samples, so a clear-on-read would only lose
  // the events that happen between the read and the clear.

  // Queue storage is sized by the header, so a deeper setting is refused
  initial begin
    if (DEPTH < 1) begin
      $error("ipm_monitor: DEPTH must be at least one");
    end
    if (DEPTH > `IPM_OUTST_MAX) begin
      $error("ipm_monitor: DEPTH larger than the stamp storage");
    end
    if (DATA_W < 8) begin
      $error("ipm_monitor: DATA_W below one byte");
    end
    if (DATA_W % 8 != 0) begin
      $error("ipm_monitor: DATA_W not a whole number of bytes");
    end
    if (`IPM_OUTST_MAX > (1 << `IPM_PTR_W)) begin
      $error("ipm_monitor: queue pointers too narrow for the stamp storage");
    end
    if (`IPM_OUTST_MAX >= (1 << `IPM_FILL_W)) begin
      $error("ipm_monitor: fill count too narrow for a full queue");
    end
  end

  ipm_pkg::ipm_mon_t cur;
  ipm_pkg::ipm_mon_t next_cur;

  logic [1:0]                  addrHs;
  logic [1:0]                  lastHs;
  logic [`IPM_CNT_W-1:0]       beatBytes [2];
  logic [1:0]                  beatHs;
  logic [`IPM_CNT_W-1:0]       wrPop;

  // Handshake events; index 0 is write, 1 is read
  assign addrHs[0] = bus.awValid & bus.awReady;
  assign addrHs[1] = bus.arValid & bus.arReady;
  assign beatHs[0] = bus.wValid & bus.wReady;
  assign beatHs[1] = bus.rValid & bus.rReady;
  assign lastHs[0] = beatHs[0] & bus.wLast;
  assign lastHs[1] = beatHs[1] & bus.rLast;

  // Write beats count their enabled lanes; read beats are full width
  always_comb begin
    wrPop = '0;
    for (int i = 0; i < BYTES; i++) begin
      wrPop = wrPop + {{(`IPM_CNT_W-1){1'b0}}, bus.wStrb[i]};
    end
    beatBytes[0] = wrPop;
    beatBytes[1] = BYTES[`IPM_CNT_W-1:0];
  end

  assign bus.sampleAck  = cur.ack;
  assign bus.sampleData = cur.data;
  assign trackFault     = cur.fault;

  // Next-state logic; both directions share one loop body
  always_comb begin
    logic [2:0]                cBytes;
    logic [2:0]                cLat;
    logic [2:0]                cTrans;
    logic                      pushOk;
    logic                      popOk;
    cBytes   = '0;
    cLat     = '0;
    cTrans   = '0;
    pushOk   = 1'b0;
    popOk    = 1'b0;
    next_cur = cur;
    next_cur.now = cur.now + 1'b1;

    for (int d = 0; d < 2; d++) begin
      cBytes = (d == 0) ? `IPM_IDX_WR_BYTES : `IPM_IDX_RD_BYTES;
      cLat   = (d == 0) ? `IPM_IDX_WR_LAT   : `IPM_IDX_RD_LAT;
      cTrans = (d == 0) ? `IPM_IDX_WR_TRANS : `IPM_IDX_RD_TRANS;

      // Byte totals wrap modulo 2^32, so host deltas stay correct
      if (beatHs[d]) begin
        next_cur.cnt[cBytes] = cur.cnt[cBytes] + beatBytes[d];
      end

      // Completed transaction: count it, close its latency window
      if (lastHs[d]) begin
        next_cur.cnt[cTrans] = cur.cnt[cTrans] + 1'b1;
      end

      popOk  = lastHs[d] && (cur.fill[d] != '0);
      pushOk = addrHs[d] && (cur.early[d] == '0)
               && !(lastHs[d] && cur.fill[d] == '0);

      if (popOk) begin
        // In-order completion is assumed: the oldest stamp is ours
        next_cur.cnt[cLat] = cur.cnt[cLat]
                             + (cur.now - cur.stamp[d][cur.head[d]]);
        next_cur.head[d]   = cur.head[d] + 1'b1;
      end else if (lastHs[d] && !addrHs[d]) begin
        // Data finished ahead of its address; latency for it is zero
        if (cur.early[d] == DEPTH[`IPM_FILL_W-1:0]) begin
          next_cur.fault = 1'b1;
        end else begin
          next_cur.early[d] = cur.early[d] + 1'b1;
        end
      end

      if (addrHs[d] && cur.early[d] != '0) begin
        next_cur.early[d] = cur.early[d] - 1'b1;
      end

      // Stamp the address cycle so latency counts from acceptance
      if (pushOk) begin
        if (cur.fill[d] == DEPTH[`IPM_FILL_W-1:0]) begin
          next_cur.fault = 1'b1;
          pushOk = 1'b0;
        end else begin
          next_cur.stamp[d][cur.tail[d]] = cur.now;
          next_cur.tail[d] = (cur.tail[d] == `IPM_PTR_W'(DEPTH - 1))
                             ? '0 : cur.tail[d] + 1'b1;
        end
      end
      if (popOk && cur.head[d] == `IPM_PTR_W'(DEPTH - 1)) begin
        next_cur.head[d] = '0;
      end
      next_cur.fill[d] = cur.fill[d] + {5'h00, pushOk} - {5'h00, popOk};
    end

    // Sample port reads a counter without disturbing it
    next_cur.ack = bus.sampleReq && !cur.ack;
    if (bus.sampleReq && !cur.ack) begin
      next_cur.data = (bus.sampleIdx < `IPM_NUM_CNT)
                      ? cur.cnt[bus.sampleIdx] : '0;
    end
  end

  // Single register bank for the whole monitor state; the stamp array is
  // wide, but keeping it in the one struct makes reset and update uniform
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

endmodule

// File: hw/ipm_sampler.sv
// Host-side sampler: reads all six counters every interval, forms the
// deltas and the average latencies. Assumes the monitor shares mclk.
`timescale 1ns/10ps
`include "ipm_params.svh"

module ipm_sampler #(
  parameter int SAMPLE_CYCLES = `IPM_SAMPLE_CYC
) (
  input  wire logic                   mclk,
  input  wire logic                   sys_rst,
  ipm_if.sampler                      bus,
  output logic                        sampleDone,
  output logic [`IPM_CNT_W-1:0]       wrBytesDelta,
  output logic [`IPM_CNT_W-1:0]       rdBytesDelta,
  output logic [`IPM_CNT_W-1:0]       wrTransDelta,
  output logic [`IPM_CNT_W-1:0]       rdTransDelta,
  output logic [`IPM_CNT_W-1:0]       wrAvgLatency,
  output logic [`IPM_CNT_W-1:0]       rdAvgLatency
);

  initial begin
    if (SAMPLE_CYCLES < 16 || SAMPLE_CYCLES > 32'h7fffffff)
      $error("ipm_sampler: unsupported SAMPLE_CYCLES");
  end

  ipm_pkg::ipm_host_t cur;
  ipm_pkg::ipm_host_t next_cur;

  assign bus.sampleReq = (cur.st == ipm_pkg::IPM_FETCH);
  assign bus.sampleIdx = cur.idx;
  assign sampleDone    = cur.done;
  assign wrBytesDelta  = cur.delta[`IPM_IDX_WR_BYTES];
  assign rdBytesDelta  = cur.delta[`IPM_IDX_RD_BYTES];
  assign wrTransDelta  = cur.delta[`IPM_IDX_WR_TRANS];
  assign rdTransDelta  = cur.delta[`IPM_IDX_RD_TRANS];
  assign wrAvgLatency  = cur.avgWr;
  assign rdAvgLatency  = cur.avgRd;

  // Interval timer, fetch loop and a shared restoring divider
  always_comb begin
    logic [`IPM_CNT_W:0]   trial;
    logic [`IPM_CNT_W-1:0] divisor;
    divisor  = (cur.st == ipm_pkg::IPM_DIVW) ? cur.delta[`IPM_IDX_WR_TRANS]
                                             : cur.delta[`IPM_IDX_RD_TRANS];
    trial    = '0;
    next_cur = cur;
    next_cur.done = 1'b0;
    case (cur.st)
      ipm_pkg::IPM_WAIT: begin
        next_cur.timer = cur.timer + 1'b1;
        if (cur.timer == `IPM_CNT_W'(SAMPLE_CYCLES - 1)) begin
          next_cur.timer = '0;
          next_cur.idx   = '0;
          next_cur.st    = ipm_pkg::IPM_FETCH;
        end
      end
      ipm_pkg::IPM_FETCH: begin
        if (bus.sampleAck) begin
          // Difference modulo 2^32 survives a counter wrap
          next_cur.delta[cur.idx] = bus.sampleData - cur.prev[cur.idx];
          next_cur.prev[cur.idx]  = bus.sampleData;
          next_cur.idx = cur.idx + 1'b1;
          if (cur.idx == `IPM_IDX_W'(`IPM_NUM_CNT - 1)) begin
            next_cur.st   = ipm_pkg::IPM_DIVW;
            next_cur.step = '0;
            next_cur.rem  = '0;
            // Write latency delta was fetched at index one, so it is settled here
            next_cur.quo  = cur.delta[`IPM_IDX_WR_LAT];
          end
        end
      end
      ipm_pkg::IPM_DIVW,
      ipm_pkg::IPM_DIVR: begin
        // One quotient bit per cycle keeps the divider small
        trial = {cur.rem, cur.quo[`IPM_CNT_W-1]} - {1'b0, divisor};
        if (!trial[`IPM_CNT_W]) begin
          next_cur.rem = trial[`IPM_CNT_W-1:0];
          next_cur.quo = {cur.quo[`IPM_CNT_W-2:0], 1'b1};
        end else begin
          next_cur.rem = {cur.rem[`IPM_CNT_W-2:0], cur.quo[`IPM_CNT_W-1]};
          next_cur.quo = {cur.quo[`IPM_CNT_W-2:0], 1'b0};
        end
        next_cur.step = cur.step + 1'b1;
        if (cur.step == 6'(`IPM_CNT_W - 1)) begin
          next_cur.step = '0;
          next_cur.rem  = '0;
          if (cur.st == ipm_pkg::IPM_DIVW) begin
            // No completed transactions means no average: report zero
            next_cur.avgWr = (divisor == '0) ? '0 : next_cur.quo;
            next_cur.quo   = cur.delta[`IPM_IDX_RD_LAT];
            next_cur.st    = ipm_pkg::IPM_DIVR;
          end else begin
            next_cur.avgRd = (divisor == '0) ? '0 : next_cur.quo;
            next_cur.st    = ipm_pkg::IPM_DONE;
          end
        end
      end
      ipm_pkg::IPM_DONE: begin
        // First pass only establishes the baseline snapshot
        next_cur.done   = cur.primed;
        next_cur.primed = 1'b1;
        next_cur.st     = ipm_pkg::IPM_WAIT;
      end
      default: begin
        next_cur.st = ipm_pkg::IPM_WAIT;
      end
    endcase
  end

  // Single register bank for the whole sampler state
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cur    <= '0;
      cur.st <= ipm_pkg::IPM_WAIT;
    end else begin
      cur <= next_cur;
    end
  end

endmodule

// File: verification/ipm_props.sv
// Checker on the sample port and read channel of the monitor interface.
// Assumes one mclk domain and a 32-bit data bus on the observed side.
`timescale 1ns/10ps
`include "ipm_params.svh"
module ipm_props (
  input wire logic                  mclk,
  input wire logic                  sys_rst,
  input wire logic                  rValid,
  input wire logic                  rReady,
  input wire logic                  rLast,
  input wire logic                  sampleReq,
  input wire logic [`IPM_IDX_W-1:0] sampleIdx,
  input wire logic                  sampleAck,
  input wire logic [`IPM_CNT_W-1:0] sampleData
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  logic        rBeat;
  logic [31:0] beatsSeen;
  logic [31:0] lastsSeen;
  assign rBeat = rValid && rReady;

  // Own tally of read beats and lasts; wraps like the counters do
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      beatsSeen <= 32'h0;
      lastsSeen <= 32'h0;
    end else begin
      beatsSeen <= beatsSeen + {31'h0, rBeat};
      lastsSeen <= lastsSeen + {31'h0, rBeat && rLast};
    end
  end

  ack_after_req_a: assert property (sampleReq && !sampleAck |=> sampleAck)
    else $error("sample request not answered next cycle");
  ack_one_cycle_a: assert property (sampleAck |=> !sampleAck)
    else $error("sample ack longer than one cycle");
  no_stray_ack_a: assert property ($rose(sampleAck) |-> $past(sampleReq))
    else $error("sample ack without request");
  idx_steady_a: assert property (sampleReq && !sampleAck |=> $stable(sampleIdx))
    else $error("sample index moved before ack");
  data_hold_a: assert property (!sampleAck |-> $stable(sampleData))
    else $error("sample data changed without ack");
  idx_range_a: assert property (sampleReq |-> sampleIdx <= `IPM_IDX_RD_TRANS)
    else $error("sample index outside six counters");
  // Quiet read channel for two cycles, so the snapshot and tally line up
  rd_bytes_match_a: assert property (sampleAck && sampleIdx == `IPM_IDX_RD_BYTES
    && !$past(rBeat) && !$past(rBeat, 2) |-> sampleData == {beatsSeen[29:0], 2'h0})
    else $error("read byte counter differs from beats seen");
  rd_trans_match_a: assert property (sampleAck && sampleIdx == `IPM_IDX_RD_TRANS
    && !$past(rBeat) && !$past(rBeat, 2) |-> sampleData == lastsSeen)
    else $error("read transaction counter differs from lasts seen");
  reset_clear_a: assert property (disable iff (1'b0) sys_rst |=> !sampleAck && sampleData == 32'h0)
    else $error("sample port not cleared by reset");

  cover property (sampleReq && !sampleAck);
  cover property (sampleAck && sampleIdx == `IPM_IDX_RD_TRANS);
  cover property (rBeat && rLast);
endmodule

// File: verification/axi_profile_counter_monitor_tb_top.sv
// Bench for both ends of the interface performance monitor joined by ipm_if.
// Assumes a short sample interval, so each burst of traffic ends before a fetch.
`timescale 1ns/10ps
`include "ipm_params.svh"
module axi_profile_counter_monitor_tb_top;
  logic        mclk;
  logic        sys_rst;
  logic        trackFault;
  logic        sampleDone;
  logic [31:0] wrB, rdB, wrT, rdT, wrA, rdA;
  logic [31:0] d [6];
  int          miscompares;
  int          check_count;
  int          cyc;

  ipm_if ipm_if_i ();
  ipm_monitor #(.DATA_W(32)) ipm_monitor_i (.mclk(mclk), .sys_rst(sys_rst), .bus(ipm_if_i),
    .trackFault(trackFault));
  ipm_sampler #(.SAMPLE_CYCLES(400)) ipm_sampler_i (.mclk(mclk), .sys_rst(sys_rst),
    .bus(ipm_if_i), .sampleDone(sampleDone), .wrBytesDelta(wrB), .rdBytesDelta(rdB),
    .wrTransDelta(wrT), .rdTransDelta(rdT), .wrAvgLatency(wrA), .rdAvgLatency(rdA));
  ipm_props ipm_props_i (.mclk(mclk), .sys_rst(sys_rst), .rValid(ipm_if_i.rValid),
    .rReady(ipm_if_i.rReady), .rLast(ipm_if_i.rLast), .sampleReq(ipm_if_i.sampleReq),
    .sampleIdx(ipm_if_i.sampleIdx), .sampleAck(ipm_if_i.sampleAck),
    .sampleData(ipm_if_i.sampleData));

  // Clock at 100 MHz
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic summarize;
    $display("Checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Hang guard: generous against about 5700 cycles of planned work
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      summarize();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] want);
    check_count++;
    if (got !== want) begin
      miscompares++;
      $display("BAD %0t got %h want %h", $time, got, want);
    end
  endtask

  function automatic logic [31:0] avg(input logic [31:0] l, input logic [31:0] t);
    return (t == 32'h0) ? 32'h0 : l / t;
  endfunction

  // One transaction: address at step 0, last beat at step lat; stalled valids
  // before the first beat must not count, so they are thrown in at random
  task automatic xfer(input logic wr, input int beats, input int lat);
    logic [3:0] s;
    logic       beat;
    logic       stall;
    for (int k = 0; k <= lat; k++) begin
      s = 4'($urandom);
      beat = k > lat - beats;
      stall = !beat && $urandom_range(1, 0) == 1;
      @(posedge mclk);
      {ipm_if_i.awValid, ipm_if_i.awReady} <= {2{wr && k == 0}};
      {ipm_if_i.arValid, ipm_if_i.arReady} <= {2{!wr && k == 0}};
      {ipm_if_i.wValid, ipm_if_i.wReady} <= {wr && (beat || stall), wr && beat};
      {ipm_if_i.rValid, ipm_if_i.rReady} <= {!wr && (beat || stall), !wr && beat};
      {ipm_if_i.wLast, ipm_if_i.rLast} <= {wr && k == lat, !wr && k == lat};
      ipm_if_i.wStrb <= s;
      if (beat) d[wr ? 0 : 3] += wr ? 32'($countones(s)) : 32'h4;
    end
    d[wr ? 1 : 4] += 32'(lat);
    d[wr ? 2 : 5] += 32'h1;
  endtask

  task automatic waitDone;
    int t;
    for (t = 0; t < 2000 && sampleDone !== 1'b1; t++) @(posedge mclk);
    if (t == 2000) begin
      miscompares++;
      $display("BAD %0t no sample done", $time);
    end
  endtask

  // One sample interval of traffic, then compare the sampler's results
  task automatic run(input int id, input int n);
    int beats;
    for (int j = 0; j < 6; j++) d[j] = 32'h0;
    if (id == 1) begin
      xfer(1'b1, 1, 0);
      xfer(1'b0, 8, 7);
      xfer(1'b1, 4, 3);
    end
    for (int i = 0; i < n; i++) begin
      beats = $urandom_range(4, 1);
      xfer(1'($urandom), beats, $urandom_range(8, beats - 1));
    end
    @(posedge mclk);
    {ipm_if_i.awValid, ipm_if_i.wValid, ipm_if_i.arValid, ipm_if_i.rValid} <= 4'h0;
    waitDone();
    check(wrB, d[0]);
    check(wrT, d[2]);
    check(wrA, avg(d[1], d[2]));
    check(rdB, d[3]);
    check(rdT, d[5]);
    check(rdA, avg(d[4], d[5]));
    check(32'(trackFault), 32'h0);
    $display("Test %0d ended", id);
  endtask

  // Quiet bus from time zero; reset for three cycles
  initial begin
    sys_rst = 1'b1;
    {ipm_if_i.awValid, ipm_if_i.awReady, ipm_if_i.arValid, ipm_if_i.arReady} = 4'h0;
    {ipm_if_i.wValid, ipm_if_i.wReady, ipm_if_i.wLast} = 3'h0;
    {ipm_if_i.rValid, ipm_if_i.rReady, ipm_if_i.rLast} = 3'h0;
    ipm_if_i.wStrb = 4'h0;
    void'($urandom(32'h5114));
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    waitDone();
    run(0, 0);
    run(1, 0);
    for (int i = 2; i < 10; i++) run(i, $urandom_range(6, 1));
    summarize();
  end
endmodule
